// *** hdl/tcr5_top.sv ***
// Purpose: configuration register five with apb access and pin steering
// Assumes: temperatures arrive in twos complement from the measurement path
// Notes: limits are stored in the current format and recoded on a change
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module tcr5_top
    import tcr5_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [7:0] TEMP_R1,
    input wire logic [7:0] TEMP_LOC,
    input wire logic [7:0] TEMP_R2,
    input wire logic OVERTEMP_PIN_I,
    output logic OVERTEMP_PIN_O,
    output logic OVERTEMP_PIN_OE_N,
    input wire logic GP_PIN6_I,
    input wire logic GP_PIN6_LEVEL,
    output logic GP_PIN6_O,
    output logic GP_PIN6_OE_N,
    output logic VOLTAGE_ID_PIN_SELECT,
    output logic TEMP_FORMAT_SELECT,
    output logic OFFSET_RANGE_SELECT
);
    import tcr5_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [2:0] sync1_ff, sync2_ff;
    logic [2:0] nxt_sync1, nxt_sync2;
    always_comb begin
        nxt_sync1 = {OVERTEMP_PIN_I, GP_PIN6_I, GP_PIN6_LEVEL};
        nxt_sync2 = sync1_ff;
    end
    always_ff @(posedge CLOCK) begin
        sync1_ff <= nxt_sync1;
        sync2_ff <= nxt_sync2;
    end

    // ==========================================================
    // register file and apb slave
    logic [7:0] cfg5_ff, cfg4_ff, lim_r1_ff, lim_loc_ff, lim_r2_ff;
    logic lock_ff;
    logic [7:0] nxt_cfg5, nxt_cfg4, nxt_lim_r1, nxt_lim_loc, nxt_lim_r2;
    logic nxt_lock;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [2:0] drive_ff, nxt_drive;
    logic gp_o_ff, gp_oe_n_ff, ot_o_ff, ot_oe_n_ff;
    logic nxt_gp_o, nxt_gp_oe_n, nxt_ot_o, nxt_ot_oe_n;

    logic access, hit, aligned, wr;
    logic [7:0] idx, wdat;
    logic fmt_flip;

    // recode a stored limit between the two formats
    function automatic logic [7:0] tcr5_recode(input logic [7:0] v,
                                               input logic to_twos);
        logic [7:0] r;
        r = to_twos ? v - TCR5_OFS64_BIAS : v + TCR5_OFS64_BIAS;
        if (to_twos && v == TCR5_DIS_OFS64) begin
            r = TCR5_DIS_TWOS;
        end
        if (!to_twos && v == TCR5_DIS_TWOS) begin
            r = TCR5_DIS_OFS64;
        end
        return r;
    endfunction : tcr5_recode

    // convert a twos complement reading into the selected format
    function automatic logic [7:0] tcr5_fmt(input logic [7:0] v,
                                            input logic twos);
        return twos ? v : v + TCR5_OFS64_BIAS;
    endfunction : tcr5_fmt

    always_comb begin
        access = PSEL && PENABLE && !pready_ff;
        aligned = (PADDR[1:0] == 2'b00) && (PADDR[31:10] == 22'h0);
        idx = PADDR[9:2];
        wdat = PWDATA[7:0];
        hit = aligned && (idx == TCR5_IDX_CFG5 || idx == TCR5_IDX_CFG4 ||
              idx == TCR5_IDX_LOCK || idx == TCR5_IDX_LIM_R1 ||
              idx == TCR5_IDX_LIM_LOC || idx == TCR5_IDX_LIM_R2 ||
              idx == TCR5_IDX_STAT || idx == TCR5_IDX_TEMP_R1 ||
              idx == TCR5_IDX_TEMP_LOC || idx == TCR5_IDX_TEMP_R2);
        wr = access && PWRITE && hit;
        nxt_cfg5 = cfg5_ff;
        nxt_cfg4 = cfg4_ff;
        nxt_lock = lock_ff;
        nxt_lim_r1 = lim_r1_ff;
        nxt_lim_loc = lim_loc_ff;
        nxt_lim_r2 = lim_r2_ff;
        fmt_flip = 1'b0;
        if (wr && !lock_ff) begin
            case (idx)
                TCR5_IDX_CFG5: begin
                    nxt_cfg5 = wdat;
                    fmt_flip = wdat[TCR5_B_FMT] != cfg5_ff[TCR5_B_FMT];
                end
                TCR5_IDX_CFG4: nxt_cfg4 = wdat;
                TCR5_IDX_LOCK: nxt_lock = wdat[0];
                TCR5_IDX_LIM_R1: nxt_lim_r1 = wdat;
                TCR5_IDX_LIM_LOC: nxt_lim_loc = wdat;
                TCR5_IDX_LIM_R2: nxt_lim_r2 = wdat;
                default: ;
            endcase
        end
        if (fmt_flip) begin
            nxt_lim_r1 = tcr5_recode(lim_r1_ff, wdat[TCR5_B_FMT]);
            nxt_lim_loc = tcr5_recode(lim_loc_ff, wdat[TCR5_B_FMT]);
            nxt_lim_r2 = tcr5_recode(lim_r2_ff, wdat[TCR5_B_FMT]);
        end
        nxt_pready = access;
        nxt_pslverr = access && !hit;
        nxt_prdata = prdata_ff;
        if (access && !PWRITE) begin
            nxt_prdata = 32'h0;
            case (idx)
                TCR5_IDX_CFG5: nxt_prdata[7:0] = cfg5_ff;
                TCR5_IDX_CFG4: nxt_prdata[7:0] = cfg4_ff;
                TCR5_IDX_LOCK: nxt_prdata[0] = lock_ff;
                TCR5_IDX_LIM_R1: nxt_prdata[7:0] = lim_r1_ff;
                TCR5_IDX_LIM_LOC: nxt_prdata[7:0] = lim_loc_ff;
                TCR5_IDX_LIM_R2: nxt_prdata[7:0] = lim_r2_ff;
                TCR5_IDX_STAT: nxt_prdata[4:0] = {drive_ff, sync2_ff[1],
                                                  sync2_ff[2]};
                TCR5_IDX_TEMP_R1: nxt_prdata[7:0] =
                    tcr5_fmt(TEMP_R1, cfg5_ff[TCR5_B_FMT]);
                TCR5_IDX_TEMP_LOC: nxt_prdata[7:0] =
                    tcr5_fmt(TEMP_LOC, cfg5_ff[TCR5_B_FMT]);
                TCR5_IDX_TEMP_R2: nxt_prdata[7:0] =
                    tcr5_fmt(TEMP_R2, cfg5_ff[TCR5_B_FMT]);
                default: nxt_prdata = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // overtemperature and pin 6 steering
    logic [7:0] r1_f, loc_f, r2_f, dis_code;
    logic gp6_active;
    always_comb begin
        r1_f = tcr5_fmt(TEMP_R1, cfg5_ff[TCR5_B_FMT]);
        loc_f = tcr5_fmt(TEMP_LOC, cfg5_ff[TCR5_B_FMT]);
        r2_f = tcr5_fmt(TEMP_R2, cfg5_ff[TCR5_B_FMT]);
        dis_code = cfg5_ff[TCR5_B_FMT] ? TCR5_DIS_TWOS : TCR5_DIS_OFS64;
        // twos compare by flipping sign, offset-64 is already unsigned
        nxt_drive[0] = cfg5_ff[TCR5_B_R1] && lim_r1_ff != dis_code &&
            ({r1_f[7] ^ cfg5_ff[TCR5_B_FMT], r1_f[6:0]} >
             {lim_r1_ff[7] ^ cfg5_ff[TCR5_B_FMT], lim_r1_ff[6:0]});
        nxt_drive[1] = cfg5_ff[TCR5_B_LOC] && lim_loc_ff != dis_code &&
            ({loc_f[7] ^ cfg5_ff[TCR5_B_FMT], loc_f[6:0]} >
             {lim_loc_ff[7] ^ cfg5_ff[TCR5_B_FMT], lim_loc_ff[6:0]});
        nxt_drive[2] = cfg5_ff[TCR5_B_R2] && lim_r2_ff != dis_code &&
            ({r2_f[7] ^ cfg5_ff[TCR5_B_FMT], r2_f[6:0]} >
             {lim_r2_ff[7] ^ cfg5_ff[TCR5_B_FMT], lim_r2_ff[6:0]});
        if (cfg4_ff[TCR5_B_GDIS]) begin
            nxt_drive = 3'b000;
        end
        // open drain, active low: pull low while any channel is hot
        nxt_ot_o = 1'b0;
        nxt_ot_oe_n = !(|drive_ff);
        gp6_active = cfg4_ff[1:0] == TCR5_FUNC_GP6;
        nxt_gp_oe_n = !(gp6_active && cfg5_ff[TCR5_B_DIR]);
        nxt_gp_o = cfg5_ff[TCR5_B_POL] ? sync2_ff[0] : !sync2_ff[0];
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cfg5_ff <= TCR5_RST_CFG5;
            cfg4_ff <= TCR5_RST_CFG4;
            lock_ff <= 1'b0;
            lim_r1_ff <= TCR5_RST_LIM;
            lim_loc_ff <= TCR5_RST_LIM;
            lim_r2_ff <= TCR5_RST_LIM;
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            drive_ff <= 3'b000;
            ot_o_ff <= 1'b0;
            ot_oe_n_ff <= 1'b1;
            gp_o_ff <= 1'b0;
            gp_oe_n_ff <= 1'b1;
        end else begin
            cfg5_ff <= nxt_cfg5;
            cfg4_ff <= nxt_cfg4;
            lock_ff <= nxt_lock;
            lim_r1_ff <= nxt_lim_r1;
            lim_loc_ff <= nxt_lim_loc;
            lim_r2_ff <= nxt_lim_r2;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            drive_ff <= nxt_drive;
            ot_o_ff <= nxt_ot_o;
            ot_oe_n_ff <= nxt_ot_oe_n;
            gp_o_ff <= nxt_gp_o;
            gp_oe_n_ff <= nxt_gp_oe_n;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        PRDATA = prdata_ff;
        PREADY = pready_ff;
        PSLVERR = pslverr_ff;
        OVERTEMP_PIN_O = ot_o_ff;
        OVERTEMP_PIN_OE_N = ot_oe_n_ff;
        GP_PIN6_O = gp_o_ff;
        GP_PIN6_OE_N = gp_oe_n_ff;
        VOLTAGE_ID_PIN_SELECT = cfg5_ff[TCR5_B_VID];
        TEMP_FORMAT_SELECT = cfg5_ff[TCR5_B_FMT];
        OFFSET_RANGE_SELECT = cfg5_ff[TCR5_B_OFS];
    end
endmodule : tcr5_top

// *** pkg/tcr5_pkg.sv ***
// Purpose: constants for the thermal format and pin configuration block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offset 0x7d is not a multiple of four, so 0x7c/0x7d are indices
package tcr5_pkg;
    localparam logic [7:0] TCR5_IDX_CFG5 = 8'h7c;
    localparam logic [7:0] TCR5_IDX_CFG4 = 8'h7d;
    localparam logic [7:0] TCR5_IDX_LOCK = 8'h80;
    localparam logic [7:0] TCR5_IDX_LIM_R1 = 8'h81;
    localparam logic [7:0] TCR5_IDX_LIM_LOC = 8'h82;
    localparam logic [7:0] TCR5_IDX_LIM_R2 = 8'h83;
    localparam logic [7:0] TCR5_IDX_STAT = 8'h84;
    localparam logic [7:0] TCR5_IDX_TEMP_R1 = 8'h85;
    localparam logic [7:0] TCR5_IDX_TEMP_LOC = 8'h86;
    localparam logic [7:0] TCR5_IDX_TEMP_R2 = 8'h87;
    localparam logic [7:0] TCR5_RST_CFG5 = 8'h01;
    localparam logic [7:0] TCR5_RST_CFG4 = 8'h00;
    localparam logic [7:0] TCR5_RST_LIM = 8'h7f;
    localparam int TCR5_B_FMT = 0;
    localparam int TCR5_B_OFS = 1;
    localparam int TCR5_B_DIR = 2;
    localparam int TCR5_B_POL = 3;
    localparam int TCR5_B_VID = 4;
    localparam int TCR5_B_R1 = 5;
    localparam int TCR5_B_LOC = 6;
    localparam int TCR5_B_R2 = 7;
    localparam int TCR5_B_GDIS = 2;
    localparam logic [1:0] TCR5_FUNC_GP6 = 2'b11;
    localparam logic [7:0] TCR5_DIS_OFS64 = 8'h00;
    localparam logic [7:0] TCR5_DIS_TWOS = 8'h80;
    localparam logic [7:0] TCR5_OFS64_BIAS = 8'h40;
endpackage : tcr5_pkg

// *** tb/tcr5_asserts.sv ***
// Purpose: port checks for configuration register five
// Assumes: one wait state apb slave, lock at byte address 0x200
// Notes: lock is tracked here since no port shows it
`timescale 1ns/1ps
module tcr5_asserts (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic OVERTEMP_PIN_OE_N,
    input wire logic GP_PIN6_OE_N,
    input wire logic VOLTAGE_ID_PIN_SELECT,
    input wire logic TEMP_FORMAT_SELECT,
    input wire logic OFFSET_RANGE_SELECT
);
    logic lock_ff;
    logic nxt_lock;
    logic [2:0] sel;
    assign sel = {VOLTAGE_ID_PIN_SELECT, OFFSET_RANGE_SELECT,
        TEMP_FORMAT_SELECT};
    always_comb begin
        nxt_lock = lock_ff | (PSEL & PENABLE & PREADY & PWRITE
            & (PADDR == 32'h200) & PWDATA[0]);
    end
    always_ff @(posedge CLOCK) begin
        lock_ff <= SYS_RST ? 1'b0 : nxt_lock;
    end
    // ==========================================
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    a_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_ready_after_take: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready not one cycle after take");
    a_no_idle_ready: assert property (!PSEL |=> !PREADY)
        else $error("ready without request");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_reset_load: assert property ($fell(SYS_RST) |-> sel == 3'b001
        && GP_PIN6_OE_N && OVERTEMP_PIN_OE_N) else $error("bad reset value");
    a_sel_by_write: assert property (!$stable(sel) |-> PREADY && PWRITE
        && PADDR == 32'h1f0 && !lock_ff) else $error("select moved");
    a_gp_by_write: assert property ($changed(GP_PIN6_OE_N) |->
        (PREADY && PWRITE) || ($past(PREADY) && $past(PWRITE)))
        else $error("pin six enable moved");
    a_lock_hold: assert property (lock_ff |=> $stable(sel))
        else $error("write passed lock");
endmodule : tcr5_asserts
bind tcr5_top tcr5_asserts u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OVERTEMP_PIN_OE_N(OVERTEMP_PIN_OE_N), .GP_PIN6_OE_N(GP_PIN6_OE_N),
    .VOLTAGE_ID_PIN_SELECT(VOLTAGE_ID_PIN_SELECT),
    .TEMP_FORMAT_SELECT(TEMP_FORMAT_SELECT),
    .OFFSET_RANGE_SELECT(OFFSET_RANGE_SELECT));

// *** tb/testbench.sv ***
// Purpose: self-checking bench for configuration register five
// Assumes: byte address is four times the register index
// Notes: expectations come from a small integer model
`timescale 1ns/1ps
module testbench;
    import tcr5_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, lvl = 0, gp_i = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, lfsr = 32'h5fa0;
    logic pready, perr, ot_n, gp_o, gp_n, vid, fmt, ofs;
    logic [7:0] temp = 8'h50;
    int mismatches = 0, check_count = 0, m5 = 1, m4 = 0, lk = 0;
    tcr5_top u_dut (.CLOCK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(perr), .TEMP_R1(temp), .TEMP_LOC(temp),
        .TEMP_R2(temp), .OVERTEMP_PIN_I(1'b1), .OVERTEMP_PIN_O(),
        .OVERTEMP_PIN_OE_N(ot_n), .GP_PIN6_I(gp_i), .GP_PIN6_LEVEL(lvl),
        .GP_PIN6_O(gp_o), .GP_PIN6_OE_N(gp_n), .VOLTAGE_ID_PIN_SELECT(vid),
        .TEMP_FORMAT_SELECT(fmt), .OFFSET_RANGE_SELECT(ofs));
    initial begin
        forever #10 clk = ~clk;
    end
    // ==========================================
    // tasks
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [7:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            mismatches++;
            close_out();
        end
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
        // lock freezes both config words, and itself sticks
        if (lk == 0 && idx == TCR5_IDX_CFG5) m5 = d;
        if (lk == 0 && idx == TCR5_IDX_CFG4) m4 = d;
        if (idx == TCR5_IDX_LOCK) lk = lk | d[0];
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, {24'h0, exp});
    endtask : rd
    task automatic pins;
        chk({vid, ofs, fmt}, {m5[4], m5[1], m5[0]});
        chk(gp_n, !(m4[1:0] == 2'b11 && m5[2]));
    endtask : pins
    task automatic ot(input logic exp);
        repeat (4) @(posedge clk);
        chk(ot_n, exp);
    endtask : ot
    // ==========================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(TCR5_IDX_CFG5, 8'h01);
        rd(TCR5_IDX_CFG4, 8'h00);
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            gp_i <= lfsr[8];
            wr(TCR5_IDX_CFG5, lfsr[7:0] | 8'h01);
            rd(TCR5_IDX_CFG5, m5);
            pins();
        end
        for (int i = 0; i < 32; i++) begin
            lvl <= i[4];
            wr(TCR5_IDX_CFG4, {6'h0, i[1:0]});
            wr(TCR5_IDX_CFG5, {4'h0, i[3:2], 2'b01});
            repeat (4) @(posedge clk);
            pins();
            if (!gp_n) chk(gp_o, m5[3] ? i[4] : !i[4]);
        end
        wr(TCR5_IDX_CFG4, 8'h00);
        for (int c = 0; c < 3; c++) begin
            wr(TCR5_IDX_CFG5, 8'h01);
            wr(8'(TCR5_IDX_LIM_R1 + c), 8'h20);
            ot(1'b1);
            // keep twos format while the channel enable moves
            wr(TCR5_IDX_CFG5, 8'((8'h20 << c) | 8'h01));
            ot(1'b0);
            wr(8'(TCR5_IDX_LIM_R1 + c), 8'h80);
            ot(1'b1);
            wr(8'(TCR5_IDX_LIM_R1 + c), 8'h20);
            wr(TCR5_IDX_CFG5, 8'(8'h20 << c));
            rd(8'(TCR5_IDX_LIM_R1 + c), 8'h60);
            rd(8'(TCR5_IDX_TEMP_R1 + c), 8'h90);
            ot(1'b0);
            wr(8'(TCR5_IDX_LIM_R1 + c), 8'h00);
            ot(1'b1);
        end
        wr(TCR5_IDX_LOCK, 8'h01);
        wr(TCR5_IDX_CFG5, 8'hfe);
        wr(TCR5_IDX_CFG4, 8'h03);
        rd(TCR5_IDX_CFG5, m5);
        rd(TCR5_IDX_CFG4, m4);
        pins();
        apb(1'b0, 8'hff, 8'h00, r, e);
        chk(e, 1'b1);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        m5 = 1;
        m4 = 0;
        lk = 0;
        @(posedge clk);
        rd(TCR5_IDX_CFG5, 8'h01);
        pins();
        close_out();
    end
endmodule : testbench
